//--- core/spc_map.vh
// register offsets, field positions, reset values and decode tables for the config bank
`ifndef SPC_MAP_VH
`define SPC_MAP_VH
`define SPC_IDX_PRN 8'h01
`define SPC_IDX_SER 8'h02
`define SPC_IDX_FLP 8'h03
`define SPC_RST_PRN 8'h9F
`define SPC_RST_SER 8'hDC
`define SPC_RST_FLP 8'h78
`define SPC_PRN_PWR 2
`define SPC_PRN_MODE 3
`define SPC_PRN_POL 4
`define SPC_PRN_LOCK 7
`define SPC_SER1_EN 2
`define SPC_SER1_PWR 3
`define SPC_SER2_EN 6
`define SPC_SER2_PWR 7
`define SPC_FLP_OS2 1
`define SPC_FLP_PIN_LO 2
`define SPC_FLP_OPT0 3
`define SPC_FLP_OPT1 4
`define SPC_FLP_PIN_HI 7
`define SPC_FLP_WMASK 8'hFE
`define SPC_ADDR_LPT1 10'h3BC
`define SPC_ADDR_LPT2 10'h378
`define SPC_ADDR_LPT3 10'h278
`define SPC_ADDR_COM1 10'h3F8
`define SPC_ADDR_COM2 10'h2F8
`define SPC_ADDR_338 10'h338
`define SPC_ADDR_238 10'h238
`define SPC_ADDR_3E8 10'h3E8
`define SPC_ADDR_2E8 10'h2E8
`define SPC_ADDR_2E0 10'h2E0
`define SPC_ADDR_220 10'h220
`define SPC_ADDR_228 10'h228
`endif

//--- core/spc_rate_map.v
// maps data-rate select bits onto the two rate pins per drive options
`default_nettype none
module spc_rate_map (
    // configuration
    input wire os2_mode,
    input wire [1:0] drive_opt,
    // rate select from the floppy core
    input wire [1:0] rate_sel,
    // pin control
    output reg [1:0] rate_out,
    output reg rate_oe
);
    always @* begin
        rate_out = rate_sel;
        rate_oe = 1'b1;
        if (!os2_mode) begin
            case (drive_opt)
                2'b01: begin
                    // 1000/500/300/250 -> 11/10/01/00
                    case (rate_sel)
                        2'b11: rate_out = 2'b11;
                        2'b00: rate_out = 2'b10;
                        2'b01: rate_out = 2'b01;
                        default: rate_out = 2'b00;
                    endcase
                end
                2'b11: rate_oe = 1'b0;
                default: rate_out = rate_sel;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- core/spc_config_regs.v
// indexed configuration bank: printer, serial and floppy setup registers
`default_nettype none
`include "spc_map.vh"

module spc_config_regs #(
    parameter [1:0] EXT_MODE_ECP_EPP_MASK = 2'b11
) (
    // clock and resets
    input wire clk,
    input wire rst,
    input wire por,
    // configuration port access
    input wire config_mode,
    input wire index_wr,
    input wire data_wr,
    input wire data_rd,
    input wire [7:0] wr_data,
    output reg [7:0] rd_data,
    output reg [7:0] config_index_register,
    // extended mode field from another register
    input wire [1:0] pp_ext_mode,
    // floppy core rate select
    input wire [1:0] rate_sel,
    // raw interrupt requests, active high
    input wire ser1_irq_req,
    input wire ser2_irq_req,
    input wire floppy_irq_req,
    input wire printer_irq_req,
    // interrupt pins
    output reg ser1_irq_o,
    output reg ser1_irq_oe,
    output reg ser2_irq_o,
    output reg ser2_irq_oe,
    output reg floppy_interrupt_o,
    output reg floppy_interrupt_oe,
    output reg printer_port_interrupt_o,
    output reg printer_port_interrupt_oe,
    // decoded port controls
    output reg [9:0] printer_base,
    output reg printer_en,
    output reg printer_pwr,
    output reg printer_ext_en,
    output reg [9:0] ser1_base,
    output reg ser1_en,
    output reg ser1_pwr,
    output reg [9:0] ser2_base,
    output reg ser2_en,
    output reg ser2_pwr,
    // floppy controls
    output reg enhanced_floppy_mode_two,
    output reg [1:0] floppy_mode,
    output reg rate_output_low,
    output reg rate_output_high,
    output reg rate_oe,
    // shared pin function
    output reg second_drive_sense_sel,
    output reg address_extension_pin_sel,
    output reg alt_printer_interrupt_sel
);
    localparam ST_IDLE = 2'b01;
    localparam ST_LOCKED = 2'b10;

    reg [7:0] prn_reg;
    reg [7:0] ser_reg;
    reg [7:0] flp_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [9:0] prn_base_next;
    reg [9:0] ser1_base_next;
    reg [9:0] ser2_base_next;
    reg [9:0] com3_addr;
    reg [9:0] com4_addr;
    reg [7:0] rd_next;
    reg pol_high;
    reg ext_force;
    wire [1:0] rate_pins;
    wire rate_drive;
    wire access_ok;

    // third and fourth serial address pair
    always @* begin
        case (prn_reg[6:5])
            2'b01: begin
                com3_addr = `SPC_ADDR_3E8;
                com4_addr = `SPC_ADDR_2E8;
            end
            2'b10: begin
                com3_addr = `SPC_ADDR_2E8;
                com4_addr = `SPC_ADDR_2E0;
            end
            2'b11: begin
                com3_addr = `SPC_ADDR_220;
                com4_addr = `SPC_ADDR_228;
            end
            default: begin
                com3_addr = `SPC_ADDR_338;
                com4_addr = `SPC_ADDR_238;
            end
        endcase
    end

    // shared four-code serial mapping
    function [9:0] ser_addr;
        input [1:0] code;
        input [9:0] a3;
        input [9:0] a4;
        begin
            case (code)
                2'b00: ser_addr = `SPC_ADDR_COM1;
                2'b01: ser_addr = `SPC_ADDR_COM2;
                2'b10: ser_addr = a3;
                default: ser_addr = a4;
            endcase
        end
    endfunction

    // decoders see the live fields; the registered base follows one cycle after the write
    always @* begin
        case (prn_reg[1:0])
            2'b01: prn_base_next = `SPC_ADDR_LPT1;
            2'b10: prn_base_next = `SPC_ADDR_LPT2;
            2'b11: prn_base_next = `SPC_ADDR_LPT3;
            default: prn_base_next = 10'h000;
        endcase
        ser1_base_next = ser_addr(ser_reg[1:0], com3_addr, com4_addr);
        ser2_base_next = ser_addr(ser_reg[5:4], com3_addr, com4_addr);
    end

    // lock state; only power-up returns it to idle
    assign access_ok = config_mode && state_reg[0];
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (access_ok && data_wr && config_index_register == `SPC_IDX_PRN &&
                    !wr_data[`SPC_PRN_LOCK]) begin
                    state_next = ST_LOCKED;
                end
            end
            ST_LOCKED: state_next = ST_LOCKED;
            default: state_next = ST_IDLE;
        endcase
    end

    // config registers ignore rst and load only on power-up
    always @(posedge clk) begin
        if (por) begin
            prn_reg <= `SPC_RST_PRN;
            ser_reg <= `SPC_RST_SER;
            flp_reg <= `SPC_RST_FLP;
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
            if (access_ok && data_wr) begin
                case (config_index_register)
                    `SPC_IDX_PRN: prn_reg <= wr_data;
                    `SPC_IDX_SER: ser_reg <= wr_data;
                    `SPC_IDX_FLP: flp_reg <= wr_data & `SPC_FLP_WMASK;
                    default: prn_reg <= prn_reg;
                endcase
            end
        end
    end

    // index register and read port follow the ordinary reset
    always @* begin
        rd_next = 8'h00;
        if (access_ok && data_rd) begin
            case (config_index_register)
                `SPC_IDX_PRN: rd_next = prn_reg;
                `SPC_IDX_SER: rd_next = ser_reg;
                `SPC_IDX_FLP: rd_next = {flp_reg[7:1], 1'b0};
                default: rd_next = 8'h00;
            endcase
        end
    end

    always @(posedge clk) begin
        if (rst || por) begin
            config_index_register <= 8'h00;
            rd_data <= 8'h00;
        end else begin
            if (config_mode && index_wr) begin
                config_index_register <= wr_data;
            end
            rd_data <= rd_next;
        end
    end

    spc_rate_map u_rate (
        .os2_mode(flp_reg[`SPC_FLP_OS2]),
        .drive_opt({flp_reg[`SPC_FLP_OPT1], flp_reg[`SPC_FLP_OPT0]}),
        .rate_sel(rate_sel),
        .rate_out(rate_pins),
        .rate_oe(rate_drive)
    );

    // interrupt polarity and the extended-mode override on the printer line
    always @* begin
        pol_high = prn_reg[`SPC_PRN_POL];
        ext_force = !prn_reg[`SPC_PRN_MODE] && |(pp_ext_mode & EXT_MODE_ECP_EPP_MASK);
    end

    // low-active lines float when idle, so enable tracks the request
    always @(posedge clk) begin
        if (por) begin
            ser1_irq_o <= 1'b0;
            ser1_irq_oe <= 1'b0;
            ser2_irq_o <= 1'b0;
            ser2_irq_oe <= 1'b0;
            floppy_interrupt_o <= 1'b0;
            floppy_interrupt_oe <= 1'b0;
            printer_port_interrupt_o <= 1'b0;
            printer_port_interrupt_oe <= 1'b0;
        end else begin
            ser1_irq_o <= pol_high ? ser1_irq_req : 1'b0;
            ser1_irq_oe <= pol_high | ser1_irq_req;
            ser2_irq_o <= pol_high ? ser2_irq_req : 1'b0;
            ser2_irq_oe <= pol_high | ser2_irq_req;
            floppy_interrupt_o <= pol_high ? floppy_irq_req : 1'b0;
            floppy_interrupt_oe <= pol_high | floppy_irq_req;
            if (ext_force || !pol_high) begin
                printer_port_interrupt_o <= 1'b0;
                printer_port_interrupt_oe <= printer_irq_req;
            end else begin
                printer_port_interrupt_o <= printer_irq_req;
                printer_port_interrupt_oe <= 1'b1;
            end
        end
    end

    // registered views of the fields; one cycle behind the write
    always @(posedge clk) begin
        if (por) begin
            printer_base <= `SPC_ADDR_LPT3;
            printer_en <= 1'b1;
            printer_pwr <= 1'b1;
            printer_ext_en <= 1'b0;
            ser1_base <= `SPC_ADDR_COM1;
            ser1_en <= 1'b1;
            ser1_pwr <= 1'b1;
            ser2_base <= `SPC_ADDR_COM2;
            ser2_en <= 1'b1;
            ser2_pwr <= 1'b1;
            enhanced_floppy_mode_two <= 1'b0;
            floppy_mode <= 2'b11;
            rate_output_low <= 1'b0;
            rate_output_high <= 1'b0;
            rate_oe <= 1'b0;
            // default bits 7,2 = 00 select the drive sense input
            second_drive_sense_sel <= 1'b1;
            address_extension_pin_sel <= 1'b0;
            alt_printer_interrupt_sel <= 1'b0;
        end else begin
            printer_base <= prn_base_next;
            printer_en <= |prn_reg[1:0];
            printer_pwr <= prn_reg[`SPC_PRN_PWR];
            printer_ext_en <= !prn_reg[`SPC_PRN_MODE];
            ser1_base <= ser1_base_next;
            ser1_en <= ser_reg[`SPC_SER1_EN];
            ser1_pwr <= ser_reg[`SPC_SER1_PWR];
            ser2_base <= ser2_base_next;
            ser2_en <= ser_reg[`SPC_SER2_EN];
            ser2_pwr <= ser_reg[`SPC_SER2_PWR];
            enhanced_floppy_mode_two <= flp_reg[`SPC_FLP_OS2];
            floppy_mode <= flp_reg[6:5];
            rate_output_low <= rate_pins[0];
            rate_output_high <= rate_pins[1];
            rate_oe <= rate_drive;
            // assumed coding: 00 drive sense, 01 address extension, 1x alt interrupt
            second_drive_sense_sel <= !flp_reg[`SPC_FLP_PIN_HI] &&
                !flp_reg[`SPC_FLP_PIN_LO];
            address_extension_pin_sel <= !flp_reg[`SPC_FLP_PIN_HI] &&
                flp_reg[`SPC_FLP_PIN_LO];
            alt_printer_interrupt_sel <= flp_reg[`SPC_FLP_PIN_HI];
        end
    end
endmodule
`default_nettype wire

//--- bench/spc_config_regs_asserts.sv
// concurrent checks on the configuration bank ports
`default_nettype none
module spc_config_regs_asserts (
    // clock and resets
    input wire logic clk,
    input wire logic rst,
    input wire logic por,
    // access port
    input wire logic config_mode,
    input wire logic index_wr,
    input wire logic data_wr,
    input wire logic data_rd,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] config_index_register,
    // decoded outputs
    input wire logic [9:0] printer_base,
    input wire logic printer_en,
    input wire logic [9:0] ser1_base,
    input wire logic ser1_irq_o,
    input wire logic ser1_irq_oe,
    input wire logic printer_port_interrupt_o,
    input wire logic printer_port_interrupt_oe,
    input wire logic enhanced_floppy_mode_two,
    input wire logic rate_oe,
    input wire logic second_drive_sense_sel,
    input wire logic address_extension_pin_sel,
    input wire logic alt_printer_interrupt_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (por);

    sequence s_quiet;
        !data_wr [*3];
    endsequence
    sequence s_stray_index;
        index_wr && !config_mode && !rst;
    endsequence

    a_rst_clears: assert property (
        rst |=> config_index_register == 8'h00 && rd_data == 8'h00)
        else $error("index or read data not cleared by reset");
    a_idle_rdata: assert property (
        !data_rd |=> rd_data == 8'h00)
        else $error("read data not zero without a read");
    a_unmapped_read: assert property (
        data_rd && config_index_register > 8'h03 |=> rd_data == 8'h00)
        else $error("unmapped index read not zero");
    a_reserved_bit: assert property (
        data_rd && config_index_register == 8'h03 |=> !rd_data[0])
        else $error("floppy setup bit 0 read as one");
    a_index_load: assert property (
        index_wr && config_mode && !rst |=> config_index_register == $past(wr_data))
        else $error("index write not taken");
    a_stray_index: assert property (
        s_stray_index |=> $stable(config_index_register))
        else $error("index written outside config mode");
    a_printer_map: assert property (
        printer_en |-> printer_base inside {10'h3BC, 10'h378, 10'h278})
        else $error("printer base outside the mapping");
    a_ser_drive: assert property (
        ser1_irq_o |-> ser1_irq_oe)
        else $error("serial irq high while floating");
    a_prn_drive: assert property (
        printer_port_interrupt_o |-> printer_port_interrupt_oe)
        else $error("printer irq high while floating");
    a_os2_drives: assert property (
        enhanced_floppy_mode_two [*2] |-> rate_oe)
        else $error("rate pins released in mode two");
    a_pin_onehot: assert property (
        !$past(por) |-> $onehot({second_drive_sense_sel,
        address_extension_pin_sel, alt_printer_interrupt_sel}))
        else $error("shared pin function not one-hot");
    a_quiet_hold: assert property (
        s_quiet |=> $stable(printer_base) && $stable(ser1_base))
        else $error("base address moved without a write");
endmodule

bind spc_config_regs spc_config_regs_asserts chk (.*);
`default_nettype wire

//--- bench/spc_config_regs_tb_top.sv
// self-checking bench for the configuration register bank
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module spc_config_regs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst = 1, por = 1, config_mode = 1, index_wr = 0, data_wr = 0, data_rd = 0;
    logic [7:0] wr_data = 8'h00, rd_data, config_index_register, v;
    logic [1:0] pp_ext_mode = 2'b00, rate_sel = 2'b00, floppy_mode, s;
    logic req = 0, ser1_irq_o, ser1_irq_oe, ser2_irq_o, ser2_irq_oe;
    logic floppy_interrupt_o, floppy_interrupt_oe, printer_port_interrupt_o;
    logic printer_port_interrupt_oe, printer_en, printer_pwr, printer_ext_en;
    logic ser1_en, ser1_pwr, ser2_en, ser2_pwr, enhanced_floppy_mode_two;
    logic rate_output_low, rate_output_high, rate_oe;
    logic second_drive_sense_sel, address_extension_pin_sel, alt_printer_interrupt_sel;
    logic [9:0] printer_base, ser1_base, ser2_base;
    wire ser1_irq_req = req, ser2_irq_req = req, floppy_irq_req = req, printer_irq_req = req;
    logic [9:0] c3[4] = '{10'h338, 10'h3E8, 10'h2E8, 10'h220};
    logic [9:0] c4[4] = '{10'h238, 10'h2E8, 10'h2E0, 10'h228};
    logic [9:0] lp[4] = '{10'h000, 10'h3BC, 10'h378, 10'h278};
    logic [7:0] fc[6] = '{8'h08, 8'h30, 8'h5A, 8'h04, 8'h80, 8'h18};
    int mismatches = 0, checked = 0, cyc = 0;

    spc_config_regs uut (.*);

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic acc(input logic iw, input logic dw, input logic [7:0] d);
        // only touch the strobes this call raises, so back-to-back calls never
        // assign one strobe twice in a time step
        if (iw) index_wr = 1;
        if (dw) data_wr = 1;
        wr_data = d;
        tick(1);
        if (iw) index_wr = 0;
        if (dw) data_wr = 0;
    endtask
    task automatic wreg(input logic [7:0] i, input logic [7:0] d);
        acc(1, 0, i);
        acc(0, 1, d);
        tick(3);
    endtask
    // read at the current index; data stands for one cycle only
    task automatic rd(input logic [7:0] e);
        data_rd = 1;
        tick(1);
        data_rd = 0;
        `CHK("rd_data", e, rd_data)
    endtask
    task automatic rchk(input logic [7:0] i, input logic [7:0] e);
        acc(1, 0, i);
        rd(e);
    endtask
    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    initial begin
        tick(10);
        rst = 0;
        por = 0;
        rchk(1, 8'h9F);
        rchk(2, 8'hDC);
        rchk(3, 8'h78);
        `CHK("pbase", 10'h278, printer_base)
        `CHK("sbase", {10'h3F8, 10'h2F8}, {ser1_base, ser2_base})
        `CHK("pwr_en", 6'h3F, {printer_pwr, printer_en, ser1_en, ser1_pwr,
            ser2_en, ser2_pwr})
        `CHK("floppy", 4'b0110, {enhanced_floppy_mode_two, floppy_mode,
            rate_oe})
        `CHK("pin0", 3'b100, {second_drive_sense_sel, address_extension_pin_sel,
            alt_printer_interrupt_sel})
        `CHK("ext", 1'b0, printer_ext_en)
        // unmapped index and writes outside config mode are all dropped
        wreg(7, 8'h55);
        rchk(7, 8'h00);
        wreg(2, 8'hFE);
        config_mode = 0;
        acc(1, 1, 8'h00);
        config_mode = 1;
        rd(8'hFE);
        rchk(2, 8'hFE);
        for (int k = 0; k < 4; k++) begin
            v = {1'b1, k[1:0], 3'b111, k[1:0]};
            wreg(1, v);
            rd(v);
            `CHK("pen", k != 0, printer_en)
            if (k != 0) `CHK("pbase", lp[k], printer_base)
            `CHK("com3", c3[k], ser1_base)
            `CHK("com4", c4[k], ser2_base)
        end
        wreg(2, 8'h10);
        `CHK("sbase", {10'h3F8, 10'h2F8}, {ser1_base, ser2_base})
        `CHK("sctl", 4'h0, {ser1_en, ser1_pwr, ser2_en, ser2_pwr})
        wreg(2, 8'h00);
        `CHK("s2base", 10'h3F8, ser2_base)
        wreg(1, 8'h83);
        `CHK("pctl", 2'b01, {printer_pwr, printer_ext_en})
        req = 1;
        tick(2);
        `CHK("irq_lo", 4'b0101, {ser1_irq_o, ser1_irq_oe, floppy_interrupt_o,
            floppy_interrupt_oe})
        req = 0;
        tick(2);
        `CHK("irq_idle", 3'b000, {ser2_irq_o, ser2_irq_oe, floppy_interrupt_oe})
        // printer irq only drives when requesting while epp is on, even with high polarity
        pp_ext_mode = 2'b01;
        wreg(1, 8'h93);
        req = 1;
        tick(2);
        `CHK("pirq", 6'b011111, {printer_port_interrupt_o, printer_port_interrupt_oe,
            ser1_irq_o, ser1_irq_oe, ser2_irq_o, ser2_irq_oe})
        req = 0;
        tick(2);
        `CHK("pirq_idle", 1'b0, printer_port_interrupt_oe)
        pp_ext_mode = 2'b00;
        wreg(3, 8'h79);
        rd(8'h78);
        for (int i = 0; i < 6; i++) begin
            v = fc[i];
            wreg(3, v);
            `CHK("fmode", v[6:5], floppy_mode)
            `CHK("os2", v[1], enhanced_floppy_mode_two)
            `CHK("roe", !(v[4] && v[3] && !v[1]), rate_oe)
            `CHK("pin", v[7] ? 3'b001 : (v[2] ? 3'b010 : 3'b100), {second_drive_sense_sel,
                address_extension_pin_sel, alt_printer_interrupt_sel})
            for (int r = 0; r < 4; r++) begin
                s = r[1:0];
                rate_sel = s;
                tick(3);
                if (!(v[4] && v[3] && !v[1])) `CHK("rate", (v[3] && !v[4] && !v[1]) ?
                    {~(s[1] ^ s[0]), s[0]} : s,
                    {rate_output_high, rate_output_low})
            end
        end
        rst = 1;
        tick(10);
        rst = 0;
        `CHK("index", 8'h00, config_index_register)
        rchk(3, 8'h18);
        wreg(1, 8'h1F);
        rd(8'h00);
        acc(0, 1, 8'h9C);
        tick(3);
        `CHK("pen", 1'b1, printer_en)
        por = 1;
        tick(1);
        por = 0;
        tick(2);
        rchk(1, 8'h9F);
        rchk(3, 8'h78);
        tally_and_finish();
    end
endmodule
`default_nettype wire
